// ### hw/rdc_ref_dac_amp_ctrl.sv
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
// Contract
// - Converter enable output follows control bit 7.
// - Eight-bit level register gives 256 codes.
// - Ladder code reaches the analog side only while enabled.
// - Positive source field bits 3-2 picks supply, pin or buffer.
// - Negative source bit 0 picks pin when one, ground when zero.
// - Bits 5 and 4 connect converter voltage to output pins.
// - Selected output pin loses digital driver and input detector.
// - Port read of a converter output pin returns zero.
// - Sleep and wake leave converter registers untouched.
// - Reset clears all converter bits, disabling it and its pins.
// - Converter control bits 6 and 1 read zero, ignore writes.
// - Op amp enabled only while its bit 7 is one.
// - Speed bit 6 one selects high gain-bandwidth; software sets it.
// - Unity gain bit ties output to inverting input, frees pin.
// - Channel bits 1-0 pick buffer, converter or input pin.
// - Op amp bits 5, 3, 2 read zero; all reset to zero.
// - Enabled op amp forces its output pin driver to hi-z.
// - Reset returns op amp registers to zero, disabling them.
module rdc_ref_dac_amp_ctrl #(
    parameter int ADDR_W = 4
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [1:0]        ref_pin_in,
    output logic [1:0]             ref_pin_read,
    output logic [1:0]             ref_pin_connect,
    output logic [1:0]             ref_pin_drv_off,
    output logic [1:0]             ref_pin_det_off,
    output logic                   ref_conv_enable,
    output logic [2:0]             ref_pos_sel,
    output logic                   ref_neg_sel_pin,
    output logic                   ref_neg_sel_gnd,
    output logic [7:0]             ref_ladder_code,
    output logic [1:0]             amp_enable,
    output logic [1:0]             amp_high_gbw,
    output logic [1:0]             amp_unity_gain,
    output logic [1:0]             amp_inv_pin_connect,
    output logic [1:0]             amp_out_driver_hiz,
    output logic [1:0]             amp_sel_fvr,
    output logic [1:0]             amp_sel_ref,
    output logic [1:0]             amp_sel_pin
);

    // One-hot channel decode {fvr, ref, pin}, gated by enable
    function automatic logic [2:0] amp_chan_onehot(
        input logic [1:0] chan,
        input logic       en
    );
        logic [2:0] sel;
        sel = 3'h0;
        if (en)
        begin
            if (chan == rdc_pkg::AMP_CHAN_FVR)
                sel = 3'h4;
            else if (chan == rdc_pkg::AMP_CHAN_REF)
                sel = 3'h2;
            else
                sel = 3'h1;
        end
        return sel;
    endfunction : amp_chan_onehot

    // One-hot source decode {fvr, pin, vdd}; code 3 selects nothing
    function automatic logic [2:0] ref_pos_onehot(
        input logic [1:0] pos,
        input logic       en
    );
        logic [2:0] sel;
        sel = 3'h0;
        if (en)
        begin
            case (pos)
                rdc_pkg::REF_POS_VDD: sel = 3'h1;
                rdc_pkg::REF_POS_PIN: sel = 3'h2;
                rdc_pkg::REF_POS_FVR: sel = 3'h4;
                default:              sel = 3'h0;
            endcase
        end
        return sel;
    endfunction : ref_pos_onehot

    logic [7:0]        amp_ctrl_reg [2];
    logic [7:0]        amp_ctrl_next [2];
    logic [7:0]        ref_ctrl_reg;
    logic [7:0]        ref_ctrl_next;
    logic [7:0]        ref_level_reg;
    logic [7:0]        ref_level_next;
    logic              aw_full_reg;
    logic              aw_full_next;
    logic              w_full_reg;
    logic              w_full_next;
    logic [ADDR_W-1:0] waddr_reg;
    logic [ADDR_W-1:0] waddr_next;
    logic [7:0]        wbyte_reg;
    logic [7:0]        wbyte_next;
    logic              wlane_reg;
    logic              wlane_next;
    logic              awready_reg;
    logic              awready_next;
    logic              wready_reg;
    logic              wready_next;
    logic              bvalid_reg;
    logic              bvalid_next;
    logic [1:0]        bresp_reg;
    logic [1:0]        bresp_next;
    logic              arready_reg;
    logic              arready_next;
    logic              rvalid_reg;
    logic              rvalid_next;
    logic [31:0]       rdata_reg;
    logic [31:0]       rdata_next;
    logic [1:0]        rresp_reg;
    logic [1:0]        rresp_next;
    logic              do_write;

    // Bus slave and register file; write waits for both halves
    always_comb
    begin
        amp_ctrl_next  = amp_ctrl_reg;
        ref_ctrl_next  = ref_ctrl_reg;   // Sleep never touches these
        ref_level_next = ref_level_reg;
        aw_full_next   = aw_full_reg;
        w_full_next    = w_full_reg;
        waddr_next     = waddr_reg;
        wbyte_next     = wbyte_reg;
        wlane_next     = wlane_reg;
        bvalid_next    = bvalid_reg;
        bresp_next     = bresp_reg;
        rvalid_next    = rvalid_reg;
        rdata_next     = rdata_reg;
        rresp_next     = rresp_reg;
        do_write       = aw_full_reg && w_full_reg && !bvalid_reg;
        if (s_axi_awvalid && awready_reg)
        begin
            aw_full_next = 1'b1;
            waddr_next   = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_reg)
        begin
            w_full_next = 1'b1;
            wbyte_next  = s_axi_wdata[7:0];
            wlane_next  = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready)
            bvalid_next = 1'b0;
        if (do_write)
        begin
            aw_full_next = 1'b0;
            w_full_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = rdc_pkg::RESP_OKAY;
            // Only byte lane 0 carries the eight-bit fields
            case (waddr_reg)
                rdc_pkg::AMP1_CONTROL_OFS:
                    if (wlane_reg)
                        amp_ctrl_next[0] = wbyte_reg &
                            rdc_pkg::AMP_CONTROL_MASK;
                rdc_pkg::AMP2_CONTROL_OFS:
                    if (wlane_reg)
                        amp_ctrl_next[1] = wbyte_reg &
                            rdc_pkg::AMP_CONTROL_MASK;
                rdc_pkg::REFDAC_CONTROL_OFS:
                    if (wlane_reg)
                        ref_ctrl_next = wbyte_reg &
                            rdc_pkg::REF_CONTROL_MASK;
                rdc_pkg::REFDAC_LEVEL_OFS:
                    if (wlane_reg)
                        ref_level_next = wbyte_reg;
                default:
                    bresp_next = rdc_pkg::RESP_SLVERR;
            endcase
        end
        if (s_axi_rvalid && s_axi_rready)
            rvalid_next = 1'b0;
        if (s_axi_arvalid && arready_reg)
        begin
            rvalid_next = 1'b1;
            rresp_next  = rdc_pkg::RESP_OKAY;
            rdata_next  = 32'h0000_0000;
            case (s_axi_araddr)
                rdc_pkg::AMP1_CONTROL_OFS:
                    rdata_next[7:0] = amp_ctrl_reg[0];
                rdc_pkg::AMP2_CONTROL_OFS:
                    rdata_next[7:0] = amp_ctrl_reg[1];
                rdc_pkg::REFDAC_CONTROL_OFS:
                    rdata_next[7:0] = ref_ctrl_reg;
                rdc_pkg::REFDAC_LEVEL_OFS:
                    rdata_next[7:0] = ref_level_reg;
                default:
                    rresp_next = rdc_pkg::RESP_SLVERR;
            endcase
        end
        // Ready only while the holding slot is free
        awready_next = !aw_full_next;
        wready_next  = !w_full_next;
        arready_next = !rvalid_next;
    end

    // Synchronous reset clears every field
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            amp_ctrl_reg[0] <= rdc_pkg::REG_RESET;
            amp_ctrl_reg[1] <= rdc_pkg::REG_RESET;
            ref_ctrl_reg    <= rdc_pkg::REG_RESET;
            ref_level_reg   <= rdc_pkg::REG_RESET;
            aw_full_reg     <= 1'b0;
            w_full_reg      <= 1'b0;
            waddr_reg       <= '0;
            wbyte_reg       <= 8'h00;
            wlane_reg       <= 1'b0;
            awready_reg     <= 1'b0;
            wready_reg      <= 1'b0;
            bvalid_reg      <= 1'b0;
            bresp_reg       <= rdc_pkg::RESP_OKAY;
            arready_reg     <= 1'b0;
            rvalid_reg      <= 1'b0;
            rdata_reg       <= 32'h0000_0000;
            rresp_reg       <= rdc_pkg::RESP_OKAY;
        end
        else
        begin
            amp_ctrl_reg <= amp_ctrl_next;
            ref_ctrl_reg  <= ref_ctrl_next;
            ref_level_reg <= ref_level_next;
            aw_full_reg   <= aw_full_next;
            w_full_reg    <= w_full_next;
            waddr_reg     <= waddr_next;
            wbyte_reg     <= wbyte_next;
            wlane_reg     <= wlane_next;
            awready_reg   <= awready_next;
            wready_reg    <= wready_next;
            bvalid_reg    <= bvalid_next;
            bresp_reg     <= bresp_next;
            arready_reg   <= arready_next;
            rvalid_reg    <= rvalid_next;
            rdata_reg     <= rdata_next;
            rresp_reg     <= rresp_next;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    logic [1:0] pin_s1_reg;
    logic [1:0] pin_s2_reg;
    logic [1:0] pin_s3_reg;
    logic [1:0] pin_filt_reg;
    logic [1:0] pin_filt_next;

    // Pin level counts only once stages two and three agree
    always_comb
    begin
        pin_filt_next = pin_filt_reg;
        for (int k = 0; k < 2; k++)
            if (pin_s2_reg[k] == pin_s3_reg[k])
                pin_filt_next[k] = pin_s3_reg[k];
    end

    // Three-stage synchroniser; first stage feeds only the second
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            pin_s1_reg   <= 2'h0;
            pin_s2_reg   <= 2'h0;
            pin_s3_reg   <= 2'h0;
            pin_filt_reg <= 2'h0;
        end
        else
        begin
            pin_s1_reg   <= ref_pin_in;
            pin_s2_reg   <= pin_s1_reg;
            pin_s3_reg   <= pin_s2_reg;
            pin_filt_reg <= pin_filt_next;
        end
    end

    logic       conv_en;
    logic [1:0] pin_sel;
    logic [1:0] pin_read_next;
    logic [2:0] pos_sel_next;
    logic [7:0] ladder_next;

    // Converter side decode, registered so outputs come from flops
    always_comb
    begin
        conv_en       = ref_ctrl_reg[rdc_pkg::REF_ENABLE_BIT];
        pin_sel[0]    = ref_ctrl_reg[rdc_pkg::REF_OUT1_BIT];
        pin_sel[1]    = ref_ctrl_reg[rdc_pkg::REF_OUT2_BIT];
        pos_sel_next  = ref_pos_onehot(
            ref_ctrl_reg[rdc_pkg::REF_POS_LSB +: 2], conv_en);
        ladder_next   = conv_en ? ref_level_reg : 8'h00;
        pin_read_next = pin_filt_reg & ~pin_sel;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            ref_conv_enable <= 1'b0;
            ref_pos_sel     <= 3'h0;
            ref_neg_sel_pin <= 1'b0;
            ref_neg_sel_gnd <= 1'b0;
            ref_ladder_code <= 8'h00;
            ref_pin_connect <= 2'h0;
            ref_pin_drv_off <= 2'h0;
            ref_pin_det_off <= 2'h0;
            ref_pin_read    <= 2'h0;
        end
        else
        begin
            ref_conv_enable <= conv_en;
            ref_pos_sel     <= pos_sel_next;
            ref_neg_sel_pin <= conv_en &&
                ref_ctrl_reg[rdc_pkg::REF_NEG_BIT];
            ref_neg_sel_gnd <= conv_en &&
                !ref_ctrl_reg[rdc_pkg::REF_NEG_BIT];
            ref_ladder_code <= ladder_next;
            ref_pin_connect <= pin_sel;
            ref_pin_drv_off <= pin_sel;
            ref_pin_det_off <= pin_sel;
            ref_pin_read    <= pin_read_next;
        end
    end

    // Op amp decode, one copy per amplifier
    genvar i;
    generate
        for (i = 0; i < 2; i++)
        begin : g_amp
            logic       en;
            logic [2:0] sel;
            assign en  = amp_ctrl_reg[i][rdc_pkg::AMP_ENABLE_BIT];
            assign sel = amp_chan_onehot(
                amp_ctrl_reg[i][rdc_pkg::AMP_CHAN_LSB +: 2], en);
            always_ff @(posedge clk)
            begin
                if (!rst_b)
                begin
                    amp_enable[i]          <= 1'b0;
                    amp_high_gbw[i]        <= 1'b0;
                    amp_unity_gain[i]      <= 1'b0;
                    amp_inv_pin_connect[i] <= 1'b0;
                    amp_out_driver_hiz[i]  <= 1'b0;
                    amp_sel_fvr[i]         <= 1'b0;
                    amp_sel_ref[i]         <= 1'b0;
                    amp_sel_pin[i]         <= 1'b0;
                end
                else
                begin
                    amp_enable[i]   <= en;
                    amp_high_gbw[i] <= en &&
                        amp_ctrl_reg[i][rdc_pkg::AMP_SPEED_BIT];
                    amp_unity_gain[i] <= en &&
                        amp_ctrl_reg[i][rdc_pkg::AMP_UNITY_BIT];
                    amp_inv_pin_connect[i] <= en &&
                        !amp_ctrl_reg[i][rdc_pkg::AMP_UNITY_BIT];
                    amp_out_driver_hiz[i] <= en;
                    amp_sel_fvr[i] <= sel[2];
                    amp_sel_ref[i] <= sel[1];
                    amp_sel_pin[i] <= sel[0];
                end
            end

            property p_amp_hiz;
                @(posedge clk) disable iff (!rst_b)
                amp_out_driver_hiz[i] ==
                    $past(amp_ctrl_reg[i][rdc_pkg::AMP_ENABLE_BIT]);
            endproperty
            a_amp_hiz: assert property (p_amp_hiz)
                else $error("driver not hi-z with amp enabled");

            property p_amp_sel;
                @(posedge clk) disable iff (!rst_b)
                $onehot0({amp_sel_fvr[i], amp_sel_ref[i], amp_sel_pin[i]})
                && (amp_sel_pin[i] || amp_sel_ref[i] || amp_sel_fvr[i]
                    || !amp_enable[i]);
            endproperty
            a_amp_sel: assert property (p_amp_sel)
                else $error("amp channel select not one-hot");

            property p_amp_unity;
                @(posedge clk) disable iff (!rst_b)
                amp_enable[i] |->
                    (amp_unity_gain[i] != amp_inv_pin_connect[i]);
            endproperty
            a_amp_unity: assert property (p_amp_unity)
                else $error("inverting input path wrong");

            property p_amp_fields;
                @(posedge clk) disable iff (!rst_b)
                (amp_ctrl_reg[i] & ~rdc_pkg::AMP_CONTROL_MASK) == 8'h00;
            endproperty
            a_amp_fields: assert property (p_amp_fields)
                else $error("unimplemented amp bit set");
        end
    endgenerate

    property p_ref_enable;
        @(posedge clk) disable iff (!rst_b)
        ##1 ref_conv_enable == $past(ref_ctrl_reg[rdc_pkg::REF_ENABLE_BIT]);
    endproperty
    a_ref_enable: assert property (p_ref_enable)
        else $error("converter enable mismatch");

    property p_ladder;
        @(posedge clk) disable iff (!rst_b)
        !ref_conv_enable |-> ref_ladder_code == 8'h00;
    endproperty
    a_ladder: assert property (p_ladder)
        else $error("ladder code live while disabled");

    property p_pos_sel;
        @(posedge clk) disable iff (!rst_b)
        $onehot0(ref_pos_sel) && (ref_pos_sel == 3'h0 || ref_conv_enable);
    endproperty
    a_pos_sel: assert property (p_pos_sel)
        else $error("positive source select bad");

    property p_neg_sel;
        @(posedge clk) disable iff (!rst_b)
        ref_conv_enable |-> (ref_neg_sel_pin ^ ref_neg_sel_gnd);
    endproperty
    a_neg_sel: assert property (p_neg_sel)
        else $error("negative source select bad");

    property p_pin_read;
        @(posedge clk) disable iff (!rst_b)
        ref_pin_connect != 2'h0 |->
            (ref_pin_read & ref_pin_connect) == 2'h0;
    endproperty
    a_pin_read: assert property (p_pin_read)
        else $error("converter pin read not zero");

    property p_ref_fields;
        @(posedge clk) disable iff (!rst_b)
        (ref_ctrl_reg & ~rdc_pkg::REF_CONTROL_MASK) == 8'h00;
    endproperty
    a_ref_fields: assert property (p_ref_fields)
        else $error("unimplemented converter bit set");

    property p_bresp_hold;
        @(posedge clk) disable iff (!rst_b)
        s_axi_bvalid && !s_axi_bready |=>
            s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bresp_hold: assert property (p_bresp_hold)
        else $error("write response dropped");

endmodule : rdc_ref_dac_amp_ctrl

// ### hw/rdc_pkg.sv
package rdc_pkg;
    // Byte offsets of the four control words
    localparam logic [3:0] AMP1_CONTROL_OFS  = 4'h0;
    localparam logic [3:0] AMP2_CONTROL_OFS  = 4'h4;
    localparam logic [3:0] REFDAC_CONTROL_OFS = 4'h8;
    localparam logic [3:0] REFDAC_LEVEL_OFS  = 4'hC;

    // Op amp control field positions
    localparam int AMP_ENABLE_BIT  = 7;
    localparam int AMP_SPEED_BIT   = 6;
    localparam int AMP_UNITY_BIT   = 4;
    localparam int AMP_CHAN_LSB    = 0;

    // Converter control field positions
    localparam int REF_ENABLE_BIT  = 7;
    localparam int REF_OUT1_BIT    = 5;
    localparam int REF_OUT2_BIT    = 4;
    localparam int REF_POS_LSB     = 2;
    localparam int REF_NEG_BIT     = 0;

    // Implemented bits; the rest read as zero
    localparam logic [7:0] AMP_CONTROL_MASK = 8'hD3;
    localparam logic [7:0] REF_CONTROL_MASK = 8'hBD;
    localparam logic [7:0] REG_RESET        = 8'h00;

    // Channel and source codes
    localparam logic [1:0] AMP_CHAN_FVR = 2'h3;
    localparam logic [1:0] AMP_CHAN_REF = 2'h2;
    localparam logic [1:0] REF_POS_VDD  = 2'h0;
    localparam logic [1:0] REF_POS_PIN  = 2'h1;
    localparam logic [1:0] REF_POS_FVR  = 2'h2;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : rdc_pkg

// ### tb/tb_ref_dac_and_opamp_control.sv
`timescale 1ns/10ps
module tb_ref_dac_and_opamp_control;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0]  wstrb = 4'h0;
    logic [1:0]  pin_in = 2'h0;
    logic        awready, wready, bvalid, arready, rvalid, conv_en, ng_pin, ng_gnd;
    logic [1:0]  bresp, rresp, pin_rd, pin_con, drv_off, det_off;
    logic [1:0]  a_en, a_gbw, a_ug, a_inv, a_hiz, a_fvr, a_ref, a_pin;
    logic [31:0] rdata;
    logic [2:0]  pos_sel;
    logic [7:0]  code;
    logic [7:0]  sh [4];
    logic [16:0] rows [14];
    int          error_cnt = 0;
    int          check_count = 0;
    int          bready_lag = 0;

    // Free-running clock, 50 ns period
    always #25 clk = ~clk;

    rdc_ref_dac_amp_ctrl #(.ADDR_W(5)) uut (
        .clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .ref_pin_in(pin_in), .ref_pin_read(pin_rd),
        .ref_pin_connect(pin_con), .ref_pin_drv_off(drv_off),
        .ref_pin_det_off(det_off), .ref_conv_enable(conv_en),
        .ref_pos_sel(pos_sel), .ref_neg_sel_pin(ng_pin),
        .ref_neg_sel_gnd(ng_gnd), .ref_ladder_code(code),
        .amp_enable(a_en), .amp_high_gbw(a_gbw), .amp_unity_gain(a_ug),
        .amp_inv_pin_connect(a_inv), .amp_out_driver_hiz(a_hiz),
        .amp_sel_fvr(a_fvr), .amp_sel_ref(a_ref), .amp_sel_pin(a_pin)
    );

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
        begin
            $display("bench passed");
        end
        else
        begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nm, input logic [37:0] e, g);
        check_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    // Bounded waits; a stuck handshake ends the run
    task automatic axi_wr(input logic [4:0] a, input logic [7:0] d,
                          input logic [3:0] st);
        int n;
        n = 0;
        awaddr <= a; wdata <= {24'h0000_00, d}; wstrb <= st;
        awvalid <= 1'b1; wvalid <= 1'b1;
        do
        begin
            @(posedge clk); n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid && bready) break;
            if (n >= bready_lag) bready <= 1'b1;
        end while (n < 40);
        bready <= 1'b0;
        if (n >= 40) chk("write_timeout", 38'h1, 38'h0);
        if (n >= 40) tally_and_finish();
        chk("bresp", (a[4] | a[1] | a[0]) ? rdc_pkg::RESP_SLVERR
                                          : rdc_pkg::RESP_OKAY, bresp);
        @(posedge clk);
    endtask : axi_wr

    task automatic axi_rd(input logic [4:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        int n;
        n = 0;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do
        begin
            @(posedge clk); n++;
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end while (n < 40);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
        if (n >= 40) chk("read_timeout", 38'h1, 38'h0);
        if (n >= 40) tally_and_finish();
        @(posedge clk);
    endtask : axi_rd

    // Expected analog side worked out from the stored fields
    function automatic logic [37:0] model();
        logic [15:0] a;
        logic [2:0]  p;
        logic [1:0]  cn;
        logic        e, ei;
        a = 16'h0000;
        for (int i = 0; i < 2; i++)
        begin
            ei = sh[i][7];
            a[14+i] = ei; a[12+i] = ei & sh[i][6]; a[10+i] = ei & sh[i][4];
            a[8+i] = ei & ~sh[i][4]; a[6+i] = ei;
            a[4+i] = ei & (sh[i][1:0] == 2'h3);
            a[2+i] = ei & (sh[i][1:0] == 2'h2); a[i] = ei & ~sh[i][1];
        end
        e = sh[2][7];
        p = 3'b000;
        if (e && sh[2][3:2] != 2'h3) p[sh[2][3:2]] = 1'b1;
        cn = {sh[2][4], sh[2][5]};
        return {a, e, p, e & sh[2][0], e & ~sh[2][0], cn, cn, cn,
                e ? sh[3] : 8'h00, pin_in & ~cn};
    endfunction : model

    task automatic check_state();
        logic [31:0] d;
        logic [1:0]  r;
        for (int i = 0; i < 4; i++)
        begin
            axi_rd(5'(i * 4), d, r);
            chk("readback", {24'h0000_00, sh[i]}, d);
            chk("rresp", rdc_pkg::RESP_OKAY, r);
        end
        chk("analog", model(), {a_en, a_gbw, a_ug, a_inv, a_hiz, a_fvr, a_ref,
            a_pin, conv_en, pos_sel, ng_pin, ng_gnd, pin_con, drv_off,
            det_off, code, pin_rd});
    endtask : check_state

    initial
    begin
        logic [31:0] d;
        logic [1:0]  r;
        rows = '{{5'h00, 8'hFF, 4'h1}, {5'h00, 8'hC0, 4'h1},
                 {5'h00, 8'hC1, 4'hF}, {5'h04, 8'hFE, 4'h1},
                 {5'h04, 8'h53, 4'h1}, {5'h00, 8'hC2, 4'h1},
                 {5'h08, 8'hFF, 4'h1}, {5'h08, 8'h80, 4'h1},
                 {5'h0C, 8'hA5, 4'h1}, {5'h08, 8'h85, 4'h1},
                 {5'h08, 8'hA8, 4'h1}, {5'h0C, 8'h5A, 4'h0},
                 {5'h10, 8'h77, 4'h1}, {5'h08, 8'h38, 4'h1}};
        for (int i = 0; i < 4; i++) sh[i] = 8'h00;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        pin_in <= 2'h3;
        @(posedge clk);
        check_state();
        $display("test reset values done");
        // Shadow follows masks, strobe and decode
        foreach (rows[i])
        begin
            axi_wr(rows[i][16:12], rows[i][11:4], rows[i][3:0]);
            if (!(rows[i][16] | rows[i][13] | rows[i][12]) && rows[i][0])
                sh[rows[i][15:14]] = rows[i][11:4] &
                    ((rows[i][15:14] == 2'h2) ? 8'hBD :
                     (rows[i][15:14] == 2'h3) ? 8'hFF : 8'hD3);
            check_state();
        end
        $display("test register rows done");
        axi_rd(5'h10, d, r);
        chk("unmapped_data", 38'h0, d);
        chk("unmapped_resp", rdc_pkg::RESP_SLVERR, r);
        $display("test unmapped read done");
        // Late bready keeps the write response standing
        bready_lag = 4;
        axi_wr(5'h00, 8'hD3, 4'h1);
        axi_wr(5'h0C, 8'hFF, 4'h1);
        pin_in <= 2'h1;
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        chk("ready_in_reset", 38'h0, {awready, wready, arready});
        rst_b <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 4; i++) sh[i] = 8'h00;
        check_state();
        $display("test mid-run reset done");
        tally_and_finish();
    end
endmodule : tb_ref_dac_and_opamp_control
